/* core/pdc_pkg.sv */
package pdc_pkg;

	localparam logic [11:0] PDC_OFF_PUMP  = 12'h000;
	localparam logic [11:0] PDC_OFF_DELAY = 12'h004;
	localparam logic [11:0] PDC_OFF_DIV   = 12'h008;
	localparam logic [11:0] PDC_OFF_PRESC = 12'h00c;
	localparam logic [11:0] PDC_OFF_STAT  = 12'h010;

	localparam int PDC_PRESET_BIT  = 0;
	localparam int PDC_CUR_LSB     = 14;
	localparam int PDC_CUR_W       = 4;
	localparam int PDC_DLY_REF_LSB = 0;
	localparam int PDC_DLY_FB_LSB  = 3;
	localparam int PDC_DLY_W       = 3;
	localparam int PDC_RDIV_LSB    = 0;
	localparam int PDC_FDIV_LSB    = 14;
	localparam int PDC_DIV_W       = 14;
	localparam int PDC_PRESC_LSB   = 5;
	localparam int PDC_PRESC_W     = 7;
	localparam int PDC_STAT_RAT_LSB = 0;
	localparam int PDC_STAT_BAD_BIT = 8;

	localparam logic [3:0]  PDC_CUR_RST   = 4'hb;
	localparam logic [13:0] PDC_DIV_RST   = 14'h007f;
	localparam logic [6:0]  PDC_PRESC_RST = 7'h20;
	localparam logic [2:0]  PDC_DLY_RST   = 3'h0;
	localparam logic [6:0]  PDC_RATIO_RST = 7'h01;

	localparam logic [1:0] PDC_PRE_PROD  = 2'h0;
	localparam logic [1:0] PDC_PRE_DIV1  = 2'h1;
	localparam logic [1:0] PDC_PRE_SMALL = 2'h2;
	localparam logic [2:0] PDC_PRE_BASE  = 3'h2;

	localparam logic [7:0]  PDC_CUR_STEP_UA = 8'hc8;
	localparam logic [10:0] PDC_DLY_PS [8] = '{11'h000, 11'h0a0, 11'h140, 11'h1e0,
		11'h33e, 11'h46a, 11'h5aa, 11'h6d6};

endpackage : pdc_pkg

/* core/pdc_pll_cfg.sv */
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module pdc_pll_cfg
	import pdc_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic               ce,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               pfd_up,
	input  wire logic               pfd_down,
	output logic      [14:0]        ref_div_ratio,
	output logic      [14:0]        fb_div_ratio,
	output logic      [6:0]         prescale_ratio,
	output logic                    prescale_bad,
	output logic      [2:0]         ref_path_delay_code,
	output logic      [2:0]         fb_path_delay_code,
	output logic      [10:0]        ref_delay_ps,
	output logic      [10:0]        fb_delay_ps,
	output logic signed [11:0]      output_skew_ps,
	output logic      [3:0]         pump_current_code,
	output logic      [11:0]        pump_current_ua,
	output logic                    pump_hiz,
	output logic                    pump_preset_mid,
	output logic                    pump_source,
	output logic                    pump_sink
);

	function automatic logic [7:0] presc_decode(input logic [6:0] f);
		logic [2:0] s1;
		logic [3:0] s2;
		logic [6:0] prod;
		s1 = 3'(PDC_PRE_BASE + {1'b0, f[1:0]});
		s2 = 4'({1'b0, f[4:2]} + 4'h1);
		prod = 7'(({4'h0, s1} * {3'h0, s2}) << 1);
		unique case (f[6:5])
			PDC_PRE_DIV1:  presc_decode = {1'b1, PDC_RATIO_RST};
			PDC_PRE_SMALL: presc_decode = {1'b1, 4'h0, s1};
			PDC_PRE_PROD:  presc_decode = {1'b1, prod};
			default:       presc_decode = {1'b0, PDC_RATIO_RST};
		endcase
	endfunction : presc_decode

	function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
		begin
			strb_merge[i*8 +: 8] = strb[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
		end
	endfunction : strb_merge

	logic [3:0]  cur_reg, cur_next;
	logic        preset_reg, preset_next;
	logic [2:0]  dref_reg, dref_next;
	logic [2:0]  dfb_reg, dfb_next;
	logic [13:0] rdiv_reg, rdiv_next;
	logic [13:0] fdiv_reg, fdiv_next;
	logic [6:0]  presc_reg, presc_next;
	logic [6:0]  ratio_reg, ratio_next;
	logic        bad_reg, bad_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        ok_reg, ok_next;

	logic [14:0] rdr_reg, rdr_next;
	logic [14:0] fdr_reg, fdr_next;
	logic [10:0] rps_reg, rps_next;
	logic [10:0] fps_reg, fps_next;
	logic signed [11:0] skew_reg, skew_next;
	logic [11:0] ua_reg, ua_next;
	logic        hiz_reg, hiz_next;
	logic        src_reg, src_next;
	logic        snk_reg, snk_next;

	logic [31:0] rd_word;
	logic [31:0] wword;
	logic        hit;
	logic        wr_en;
	logic [7:0]  pdec;

	// Address decode and readback
	always_comb
	begin
		rd_word = 32'h0;
		hit = 1'b1;
		unique case (paddr)
			PDC_OFF_PUMP:
			begin
				rd_word[PDC_CUR_LSB +: PDC_CUR_W] = cur_reg;
				rd_word[PDC_PRESET_BIT] = preset_reg;
			end
			PDC_OFF_DELAY:
			begin
				rd_word[PDC_DLY_REF_LSB +: PDC_DLY_W] = dref_reg;
				rd_word[PDC_DLY_FB_LSB +: PDC_DLY_W] = dfb_reg;
			end
			PDC_OFF_DIV:
			begin
				rd_word[PDC_RDIV_LSB +: PDC_DIV_W] = rdiv_reg;
				rd_word[PDC_FDIV_LSB +: PDC_DIV_W] = fdiv_reg;
			end
			PDC_OFF_PRESC:
			begin
				rd_word[PDC_PRESC_LSB +: PDC_PRESC_W] = presc_reg;
			end
			PDC_OFF_STAT:
			begin
				rd_word[PDC_STAT_RAT_LSB +: PDC_PRESC_W] = ratio_reg;
				rd_word[PDC_STAT_BAD_BIT] = bad_reg;
			end
			default:
			begin
				hit = 1'b0;
			end
		endcase
	end

	assign pready  = psel & penable & ce & ok_reg;
	assign pslverr = pready & ~hit;
	assign wr_en   = pready & pwrite & hit;
	assign wword   = strb_merge(rd_word, pwdata, pstrb);
	assign pdec    = presc_decode(wword[PDC_PRESC_LSB +: PDC_PRESC_W]);

	// Bus handshake and read data
	always_comb
	begin
		ok_next = ok_reg;
		prdata_next = prdata_reg;
		if (ce)
		begin
			ok_next = psel & ~pready;
			if (psel & ~pwrite)
			begin
				prdata_next = rd_word;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ok_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end
		else
		begin
			ok_reg <= ok_next;
			prdata_reg <= prdata_next;
		end
	end

	// Configuration storage
	always_comb
	begin
		cur_next = cur_reg;
		preset_next = preset_reg;
		dref_next = dref_reg;
		dfb_next = dfb_reg;
		rdiv_next = rdiv_reg;
		fdiv_next = fdiv_reg;
		presc_next = presc_reg;
		ratio_next = ratio_reg;
		bad_next = bad_reg;
		if (wr_en)
		begin
			unique case (paddr)
				PDC_OFF_PUMP:
				begin
					cur_next = wword[PDC_CUR_LSB +: PDC_CUR_W];
					preset_next = wword[PDC_PRESET_BIT];
				end
				PDC_OFF_DELAY:
				begin
					dref_next = wword[PDC_DLY_REF_LSB +: PDC_DLY_W];
					dfb_next = wword[PDC_DLY_FB_LSB +: PDC_DLY_W];
				end
				PDC_OFF_DIV:
				begin
					rdiv_next = wword[PDC_RDIV_LSB +: PDC_DIV_W];
					fdiv_next = wword[PDC_FDIV_LSB +: PDC_DIV_W];
				end
				PDC_OFF_PRESC:
				begin
					presc_next = wword[PDC_PRESC_LSB +: PDC_PRESC_W];
					if (pdec[7])
					begin
						ratio_next = pdec[6:0];
					end
				end
				PDC_OFF_STAT:
				begin
					if (pwdata[PDC_STAT_BAD_BIT] & pstrb[PDC_STAT_BAD_BIT / 8])
					begin
						bad_next = 1'b0;
					end
				end
				default:
				begin
					bad_next = bad_reg;
				end
			endcase
		end
		if (wr_en && paddr == PDC_OFF_PRESC && !pdec[7])
		begin
			bad_next = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cur_reg <= PDC_CUR_RST;
			preset_reg <= 1'b0;
			dref_reg <= PDC_DLY_RST;
			dfb_reg <= PDC_DLY_RST;
			rdiv_reg <= PDC_DIV_RST;
			fdiv_reg <= PDC_DIV_RST;
			presc_reg <= PDC_PRESC_RST;
			ratio_reg <= PDC_RATIO_RST;
			bad_reg <= 1'b0;
		end
		else if (ce)
		begin
			cur_reg <= cur_next;
			preset_reg <= preset_next;
			dref_reg <= dref_next;
			dfb_reg <= dfb_next;
			rdiv_reg <= rdiv_next;
			fdiv_reg <= fdiv_next;
			presc_reg <= presc_next;
			ratio_reg <= ratio_next;
			bad_reg <= bad_next;
		end
	end

	// Decoded settings, taken from next values so a write acts at once
	always_comb
	begin
		rdr_next = 15'({1'b0, rdiv_next} + 15'h1);
		fdr_next = 15'({1'b0, fdiv_next} + 15'h1);
		rps_next = PDC_DLY_PS[dref_next];
		fps_next = PDC_DLY_PS[dfb_next];
		skew_next = $signed({1'b0, rps_next}) - $signed({1'b0, fps_next});
		ua_next = {4'h0, cur_next} * {4'h0, PDC_CUR_STEP_UA};
		hiz_next = (cur_next == 4'h0) & ~preset_next;
		src_next = pfd_up & ~pfd_down & ~hiz_next & ~preset_next;
		snk_next = pfd_down & ~pfd_up & ~hiz_next & ~preset_next;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rdr_reg <= 15'({1'b0, PDC_DIV_RST} + 15'h1);
			fdr_reg <= 15'({1'b0, PDC_DIV_RST} + 15'h1);
			rps_reg <= 11'h0;
			fps_reg <= 11'h0;
			skew_reg <= 12'sh0;
			ua_reg <= {4'h0, PDC_CUR_RST} * {4'h0, PDC_CUR_STEP_UA};
			hiz_reg <= 1'b0;
			src_reg <= 1'b0;
			snk_reg <= 1'b0;
		end
		else if (ce)
		begin
			rdr_reg <= rdr_next;
			fdr_reg <= fdr_next;
			rps_reg <= rps_next;
			fps_reg <= fps_next;
			skew_reg <= skew_next;
			ua_reg <= ua_next;
			hiz_reg <= hiz_next;
			src_reg <= src_next;
			snk_reg <= snk_next;
		end
	end

	assign prdata              = prdata_reg;
	assign ref_div_ratio       = rdr_reg;
	assign fb_div_ratio        = fdr_reg;
	assign prescale_ratio      = ratio_reg;
	assign prescale_bad        = bad_reg;
	assign ref_path_delay_code = dref_reg;
	assign fb_path_delay_code  = dfb_reg;
	assign ref_delay_ps        = rps_reg;
	assign fb_delay_ps         = fps_reg;
	assign output_skew_ps      = skew_reg;
	assign pump_current_code   = cur_reg;
	assign pump_current_ua     = ua_reg;
	assign pump_hiz            = hiz_reg;
	assign pump_preset_mid     = preset_reg;
	assign pump_source         = src_reg;
	assign pump_sink           = snk_reg;

endmodule : pdc_pll_cfg

/* sim/pdc_pll_cfg_sva.sv */
`timescale 1ns/1ps
module pdc_pll_cfg_sva (
	input wire logic               clk,
	input wire logic               sys_rst,
	input wire logic               ce,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	input wire logic               pfd_up,
	input wire logic               pfd_down,
	input wire logic [6:0]         prescale_ratio,
	input wire logic [10:0]        ref_delay_ps,
	input wire logic [10:0]        fb_delay_ps,
	input wire logic signed [11:0] output_skew_ps,
	input wire logic [3:0]         pump_current_code,
	input wire logic [11:0]        pump_current_ua,
	input wire logic               pump_hiz,
	input wire logic               pump_preset_mid,
	input wire logic               pump_source,
	input wire logic               pump_sink
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence held_preset;
		pump_preset_mid [*2];
	endsequence
	sequence setup_phase;
		psel && !penable && ce;
	endsequence
	sequence access_phase;
		psel && penable && ce;
	endsequence
	setup_answer_a: assert property (setup_phase ##1 access_phase |-> pready)
		else $error("no answer in first access cycle");
	ready_cause_a: assert property (pready |-> psel && penable && ce)
		else $error("ready without access");
	pump_ua_a: assert property (pump_current_ua == pump_current_code * 12'd200)
		else $error("pump current wrong");
	pump_hiz_a: assert property (pump_hiz == (pump_current_code == 4'h0 && !pump_preset_mid))
		else $error("pump hiz wrong");
	skew_sign_a: assert property (output_skew_ps == $signed({1'b0, ref_delay_ps} - {1'b0, fb_delay_ps}))
		else $error("skew wrong");
	source_cause_a: assert property ($past(ce) && pump_source |-> $past(pfd_up) && !$past(pfd_down))
		else $error("source without up");
	sink_cause_a: assert property ($past(ce) && pump_sink |-> $past(pfd_down) && !$past(pfd_up))
		else $error("sink without down");
	preset_mute_a: assert property (held_preset |-> !pump_source && !pump_sink)
		else $error("pulse during preset");
	presc_range_a: assert property (prescale_ratio inside {[7'd1:7'd80]})
		else $error("prescale out of range");
endmodule : pdc_pll_cfg_sva

/* sim/pdc_loop_model.sv */
`timescale 1ns/1ps
module pdc_loop_model (
	input  wire logic clk,
	input  wire logic lead,
	input  wire logic lag,
	input  wire logic pump_source,
	input  wire logic pump_sink,
	input  wire logic pump_preset_mid,
	output logic      pfd_up = 1'b0,
	output logic      pfd_down = 1'b0,
	output int        level
);
	always_ff @(posedge clk)
	begin
		pfd_up <= lead;
		pfd_down <= lag;
		if (pump_preset_mid)
			level <= 0;
		else
			level <= level + int'(pump_source) - int'(pump_sink);
	end
endmodule : pdc_loop_model

/* sim/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t %h %h", $time, g, e); end end
module tb;
	import pdc_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lead = 1'b0, lag = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, pfd_up, pfd_down, prescale_bad, pump_hiz, pump_preset_mid, pump_source, pump_sink, er;
	logic [14:0] ref_div_ratio, fb_div_ratio;
	logic [6:0] prescale_ratio;
	logic [2:0] ref_path_delay_code, fb_path_delay_code;
	logic [10:0] ref_delay_ps, fb_delay_ps;
	logic signed [11:0] output_skew_ps;
	logic [3:0] pump_current_code;
	logic [11:0] pump_current_ua;
	int level, n_fail = 0, comparisons = 0;
	always #4 clk = ~clk;
	pdc_pll_cfg i_dut (.clk, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .pfd_up, .pfd_down, .ref_div_ratio, .fb_div_ratio, .prescale_ratio, .prescale_bad,
		.ref_path_delay_code, .fb_path_delay_code, .ref_delay_ps, .fb_delay_ps, .output_skew_ps,
		.pump_current_code, .pump_current_ua, .pump_hiz, .pump_preset_mid, .pump_source, .pump_sink);
	pdc_loop_model i_loop (.clk, .lead, .lag, .pump_source, .pump_sink, .pump_preset_mid, .pfd_up, .pfd_down, .level);
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			n_fail++;
		@(negedge clk);
	endtask : apb
	task automatic end_of_test();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic t_presc();
		logic [6:0] f [6] = '{7'h20, 7'h40, 7'h43, 7'h00, 7'h0b, 7'h1f};
		logic [6:0] r [6] = '{7'd1, 7'd2, 7'd5, 7'd4, 7'd30, 7'd80};
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, 12'h00c, {20'h0, f[i], 5'h0}, 4'hf);
			`CHK(prescale_ratio, r[i])
		end
		apb(1'b1, 12'h00c, {20'h0, 7'h60, 5'h0}, 4'hf);
		`CHK(prescale_bad, 1'b1)
		apb(1'b0, 12'h010, 32'h0, 4'h0);
		`CHK(rd[8:0], 9'h150)
		apb(1'b1, 12'h010, 32'h100, 4'h2);
		`CHK(prescale_bad, 1'b0)
		apb(1'b0, 12'h014, 32'h0, 4'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		$display("t_presc done");
	endtask : t_presc
	task automatic t_div_delay();
		logic [10:0] ps [8] = '{11'd0, 11'd160, 11'd320, 11'd480, 11'd830, 11'd1130, 11'd1450, 11'd1750};
		apb(1'b1, 12'h008, {4'h0, 14'h3fff, 14'h0}, 4'hf);
		`CHK({ref_div_ratio, fb_div_ratio}, {15'd1, 15'd16384})
		apb(1'b1, 12'h008, 32'hff, 4'h1);
		`CHK({ref_div_ratio, fb_div_ratio}, {15'd256, 15'd16384})
		for (int k = 0; k < 8; k++)
		begin
			apb(1'b1, 12'h004, {29'h0, 3'(k)}, 4'hf);
			`CHK(output_skew_ps, {1'b0, ps[k]})
			`CHK({ref_path_delay_code, fb_path_delay_code, ref_delay_ps, fb_delay_ps}, {3'(k), 3'h0, ps[k], 11'h0})
			apb(1'b1, 12'h004, {26'h0, 3'(k), 3'h0}, 4'hf);
			`CHK(output_skew_ps, -{1'b0, ps[k]})
			`CHK({ref_path_delay_code, fb_path_delay_code, ref_delay_ps, fb_delay_ps}, {3'h0, 3'(k), 11'h0, ps[k]})
		end
		$display("t_div_delay done");
	endtask : t_div_delay
	task automatic t_pump();
		for (int k = 0; k < 16; k++)
		begin
			apb(1'b1, 12'h000, {14'h0, 4'(k), 14'h0}, 4'hf);
			`CHK({pump_hiz, pump_current_ua}, {k == 0, 12'(k * 200)})
			`CHK(pump_current_code, 4'(k))
		end
		apb(1'b1, 12'h000, {14'h0, 4'hb, 14'h1}, 4'hf);
		@(posedge clk);
		lead <= 1'b1;
		repeat (4) @(negedge clk);
		`CHK({pump_hiz, pump_source, level}, {2'b00, 32'd0})
		`CHK(pump_preset_mid, 1'b1)
		apb(1'b1, 12'h000, {14'h0, 4'hb, 14'h0}, 4'hf);
		`CHK(pump_source, 1'b1)
		`CHK(pump_preset_mid, 1'b0)
		@(posedge clk);
		lead <= 1'b0;
		lag <= 1'b1;
		repeat (3) @(negedge clk);
		`CHK({pump_source, pump_sink}, 2'b01)
		$display("t_pump done");
	endtask : t_pump
	task automatic t_hold();
		@(posedge clk);
		ce <= 1'b0;
		lag <= 1'b0;
		repeat (3) @(negedge clk);
		`CHK({pump_sink, pump_current_code}, {1'b1, 4'hb})
		fork
			apb(1'b1, PDC_OFF_PUMP, {14'h0, 4'h3, 14'h0}, 4'hf);
			begin
				repeat (4) @(posedge clk);
				ce <= 1'b1;
			end
		join
		`CHK({pump_sink, pump_current_code, pump_current_ua}, {1'b0, 4'h3, 12'd600})
		$display("t_hold done");
	endtask : t_hold
	task automatic t_reset();
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		`CHK({ref_div_ratio, fb_div_ratio, prescale_ratio, prescale_bad}, {15'd128, 15'd128, 7'd1, 1'b0})
		`CHK({pump_current_code, pump_current_ua, pump_hiz, pump_preset_mid}, {4'hb, 12'd2200, 2'b00})
		`CHK({ref_path_delay_code, fb_path_delay_code, output_skew_ps}, {6'h0, 12'h0})
		apb(1'b0, PDC_OFF_DIV, 32'h0, 4'h0);
		`CHK(rd, {4'h0, 14'h7f, 14'h7f})
		$display("t_reset done");
	endtask : t_reset
	initial
	begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		`CHK({ref_div_ratio, pump_current_ua, prescale_ratio}, {15'd128, 12'd2200, 7'd1})
		t_presc();
		t_div_delay();
		t_pump();
		t_hold();
		t_reset();
		end_of_test();
	end
	initial
	begin
		#40000;
		n_fail++;
		end_of_test();
	end
endmodule : tb
bind pdc_pll_cfg pdc_pll_cfg_sva i_sva (.clk, .sys_rst, .ce, .psel, .penable, .pready, .pfd_up, .pfd_down,
	.prescale_ratio, .ref_delay_ps, .fb_delay_ps, .output_skew_ps, .pump_current_code, .pump_current_ua,
	.pump_hiz, .pump_preset_mid, .pump_source, .pump_sink);
